// ### src/rdm_control.sv
// redriver mux configuration, termination, detect poll and path steering
// assumes straps arrive as comparator thermometer bits and a serial
// engine outside reaches the registers through the plain register port
// How it works
// - serial strap low gives pin mode, high slave, floating master
// - four-level pins resolve at 0.2, 0.5, 0.8 of supply
// - pin mode: host and switch sides use their own strap pairs
// - pin mode: idle threshold follows its own strap
// - serial mode: swing, eq, emphasis, termination set per lane
// - serial strap high switches settings to registers at once
// - serial mode: the four eq pins become four address inputs
// - idle threshold strap holds in serial mode until register override set
// - registers go to defaults at power-up and in pin mode
// - reset pin in serial mode leaves registers untouched
// - each equalizer takes an 8-bit code, all reachable by register
// - eq pins 00..R1 map to 00,01,02,03,07,15,0B,0F
// - eq pins F0..11 map to 55,1F,2F,3F,AA,7F,BF,FF
// - reset pin high: low power and every input high impedance
// - enable 0 mux, 1 fan-out, both terminate; enable R reserved
// - enable floating: select 0/R polls B side, F/1 polls A side
// - polled paths retest every 12 ms, terminate once detected
// - select 0/R drives host outputs from B, F/1 from A
// - enable 0/F: select 0/F routes host input to B, R/1 to A
// - enable 1 drives both switch outputs; R with R reserved
// - address byte is B0 hex plus twice the address inputs
`timescale 1ns/10ps
`default_nettype none
module rdm_control
    import rdm_pkg::*;
#(
    parameter int POLL_CYCLES = POLL_CYCLES_DEFAULT,
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // four-level straps as {above 0.8, above 0.5, above 0.2}
    input wire logic [2:0] serial_mode_strap,
    input wire logic [2:0] idle_threshold_strap,
    input wire logic [2:0] host_eq_pin_hi,
    input wire logic [2:0] host_eq_pin_lo,
    input wire logic [2:0] switch_eq_pin_hi,
    input wire logic [2:0] switch_eq_pin_lo,
    input wire logic [2:0] host_emph_pin_hi,
    input wire logic [2:0] host_emph_pin_lo,
    input wire logic [2:0] switch_emph_pin_hi,
    input wire logic [2:0] switch_emph_pin_lo,
    input wire logic [2:0] path_select_a,
    input wire logic [2:0] path_select_b,
    input wire logic [2:0] input_enable_strap,
    // two-level pins
    input wire logic reset_pin,
    input wire logic [LANES-1:0] rx_detect_hit,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // operating state
    output logic [1:0] op_mode,
    output logic [7:0] slave_address,
    output logic low_power,
    output logic [1:0] idle_threshold,
    // conditioning, settings 0..1 host lanes, 2..3 switch lanes
    output logic [SET_LANES-1:0][7:0] eq_code,
    output logic [SET_LANES-1:0][2:0] output_swing,
    output logic [SET_LANES-1:0][1:0] emph_level,
    // input termination and receiver detect
    output logic [LANES-1:0] term_host,
    output logic [LANES-1:0] term_switch_a,
    output logic [LANES-1:0] term_switch_b,
    output logic rx_detect_start,
    // path steering
    output logic [LANES-1:0] host_tx_from_a,
    output logic [LANES-1:0] switch_a_tx_en,
    output logic [LANES-1:0] switch_b_tx_en
);
    localparam int CNT_W = $clog2(POLL_CYCLES + 1);

    rdm_strap_if #(.N(STRAP_COUNT)) strap ();
    logic [STRAP_COUNT-1:0][2:0] strap_raw;

    // gather pins; two-level pins fill all three comparator bits
    always_comb begin
        strap_raw = '0;
        strap_raw[IDX_SERIAL] = serial_mode_strap;
        strap_raw[IDX_IDLE] = idle_threshold_strap;
        strap_raw[IDX_HEQ_HI] = host_eq_pin_hi;
        strap_raw[IDX_HEQ_LO] = host_eq_pin_lo;
        strap_raw[IDX_SEQ_HI] = switch_eq_pin_hi;
        strap_raw[IDX_SEQ_LO] = switch_eq_pin_lo;
        strap_raw[IDX_HEM_HI] = host_emph_pin_hi;
        strap_raw[IDX_HEM_LO] = host_emph_pin_lo;
        strap_raw[IDX_SEM_HI] = switch_emph_pin_hi;
        strap_raw[IDX_SEM_LO] = switch_emph_pin_lo;
        strap_raw[IDX_SEL_A] = path_select_a;
        strap_raw[IDX_SEL_B] = path_select_b;
        strap_raw[IDX_IN_EN] = input_enable_strap;
        strap_raw[IDX_RESET] = {3{reset_pin}};
        for (int i = 0; i < LANES; i++) begin
            strap_raw[IDX_DET + i] = {3{rx_detect_hit[i]}};
        end
    end

    rdm_strap_sync #(.N(STRAP_COUNT)) u_sync (
        .clock(clock),
        .rst(rst),
        .raw(strap_raw),
        .strap(strap.sync)
    );

    // resolved levels used below
    rdm_level_type lv_serial;
    rdm_level_type lv_sel_a;
    rdm_level_type lv_sel_b;
    rdm_level_type lv_in_en;
    logic rst_pin_s;
    logic [LANES-1:0] det_s;
    rdm_mode_type mode_now;
    logic serial;
    assign lv_serial = strap.level[IDX_SERIAL];
    assign lv_sel_a = strap.level[IDX_SEL_A];
    assign lv_sel_b = strap.level[IDX_SEL_B];
    assign lv_in_en = strap.level[IDX_IN_EN];
    assign rst_pin_s = (strap.level[IDX_RESET] == LVL_ONE);
    for (genvar i = 0; i < LANES; i++) begin : g_det
        assign det_s[i] = (strap.level[IDX_DET + i] == LVL_ONE);
    end

    // mode from strap; a weak R level counts as low
    always_comb begin
        unique case (lv_serial)
            LVL_ONE: mode_now = MODE_SLAVE;
            LVL_F: mode_now = MODE_MASTER;
            default: mode_now = MODE_PIN;
        endcase
    end
    assign serial = (mode_now != MODE_PIN);

    // configuration registers
    logic [7:0] ctrl_reg;
    logic [SET_LANES-1:0][7:0] eq_reg;
    logic [SET_LANES-1:0][7:0] drive_reg;
    logic cfg_clear;
    logic wr_ok;
    // defaults at power-up and in pin mode
    // the reset pin is deliberately not part of the clear
    assign cfg_clear = rst || !serial;
    assign wr_ok = reg_wr && serial;

    // control register: idle override and per-lane termination disable
    always_ff @(posedge clock) begin
        if (cfg_clear) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ok && reg_addr == REG_CTRL) begin
            ctrl_reg <= reg_wdata;
        end
    end

    // one eq and one drive register per lane
    for (genvar g = 0; g < SET_LANES; g++) begin : g_lane_reg
        always_ff @(posedge clock) begin
            if (cfg_clear) begin
                eq_reg[g] <= EQ_RESET;
            end else if (wr_ok && reg_addr == REG_EQ_BASE + 8'(g)) begin
                eq_reg[g] <= reg_wdata;
            end
        end
        always_ff @(posedge clock) begin
            if (cfg_clear) begin
                drive_reg[g] <= DRIVE_RESET;
            end else if (wr_ok && reg_addr == REG_DRIVE_BASE + 8'(g)) begin
                drive_reg[g] <= reg_wdata;
            end
        end
    end

    // receiver-detect poll
    rdm_poll_type poll_state;
    logic [CNT_W-1:0] poll_count;
    logic [LANES-1:0] detected;
    logic poll_active;
    logic reserved;

    // unmatched selects or a reserved enable level
    assign reserved = (lv_in_en == LVL_R) || (lv_sel_a != lv_sel_b);
    // poll only with enable floating, reset pin low and no reserved setting
    assign poll_active = !rst_pin_s && !reserved && (lv_in_en == LVL_F);

    // test, then retest each poll period until all lanes hit
    always_ff @(posedge clock) begin
        if (rst || !poll_active) begin
            poll_state <= POLL_OFF;
            poll_count <= '0;
            detected <= '0;
            rx_detect_start <= 1'b0;
        end else begin
            rx_detect_start <= 1'b0;
            unique case (poll_state)
                POLL_OFF: begin
                    poll_state <= POLL_TEST;
                    poll_count <= '0;
                    rx_detect_start <= 1'b1;
                end
                POLL_TEST: begin
                    if (poll_count == CNT_W'(SETTLE_CYCLES - 1)) begin
                        detected <= detected | det_s;
                        poll_count <= '0;
                        if ((detected | det_s) == '1) begin
                            poll_state <= POLL_DONE;
                        end else begin
                            poll_state <= POLL_WAIT;
                        end
                    end else begin
                        poll_count <= poll_count + 1'b1;
                    end
                end
                POLL_WAIT: begin
                    if (poll_count == CNT_W'(POLL_CYCLES - 1)) begin
                        poll_state <= POLL_TEST;
                        poll_count <= '0;
                        rx_detect_start <= 1'b1;
                    end else begin
                        poll_count <= poll_count + 1'b1;
                    end
                end
                POLL_DONE: begin
                    poll_state <= POLL_DONE;
                end
            endcase
        end
    end

    // next values of the conditioning outputs
    logic [SET_LANES-1:0][7:0] next_eq;
    logic [SET_LANES-1:0][2:0] next_swing;
    logic [SET_LANES-1:0][1:0] next_emph;
    logic [1:0] next_idle;
    logic [3:0] addr_in;
    logic [7:0] next_address;

    always_comb begin
        logic [3:0] eq_idx;
        logic [3:0] em_idx;
        eq_idx = '0;
        em_idx = '0;
        for (int g = 0; g < SET_LANES; g++) begin
            // host lanes use host pins, switch lanes switch pins
            if (g < LANES) begin
                eq_idx = {strap.level[IDX_HEQ_HI], strap.level[IDX_HEQ_LO]};
                em_idx = {strap.level[IDX_HEM_HI], strap.level[IDX_HEM_LO]};
            end else begin
                eq_idx = {strap.level[IDX_SEQ_HI], strap.level[IDX_SEQ_LO]};
                em_idx = {strap.level[IDX_SEM_HI], strap.level[IDX_SEM_LO]};
            end
            // serial mode takes registers with no delay
            if (serial) begin
                next_eq[g] = eq_reg[g];
                next_swing[g] = drive_reg[g][DRIVE_SWING_LSB +: 3];
                next_emph[g] = drive_reg[g][DRIVE_EMPH_LSB +: 2];
            end else begin
                next_eq[g] = EQ_TABLE[eq_idx];
                next_swing[g] = SWING_TABLE[em_idx];
                next_emph[g] = EMPH_TABLE[em_idx];
            end
        end
    end

    assign next_idle = (serial && ctrl_reg[CTRL_IDLE_OVR])
        ? ctrl_reg[CTRL_IDLE_LSB +: 2] : strap.level[IDX_IDLE];

    // address inputs reuse the four eq pins, high above half
    assign addr_in = {strap.level[IDX_SEQ_HI] >= LVL_F,
                      strap.level[IDX_SEQ_LO] >= LVL_F,
                      strap.level[IDX_HEQ_HI] >= LVL_F,
                      strap.level[IDX_HEQ_LO] >= LVL_F};
    // base plus twice the address inputs
    assign next_address = ADDR_BASE + {3'h0, addr_in, 1'b0};

    // termination and path decode
    logic [LANES-1:0] next_term_host;
    logic [LANES-1:0] next_term_a;
    logic [LANES-1:0] next_term_b;
    logic [LANES-1:0] next_from_a;
    logic [LANES-1:0] next_a_en;
    logic [LANES-1:0] next_b_en;

    always_comb begin
        logic poll_a;
        logic sel_hi;
        logic host_dis;
        logic sw_dis;
        // select F or 1 polls the A side
        poll_a = (lv_sel_a >= LVL_F);
        // select F or 1 feeds host outputs from A
        sel_hi = (lv_sel_a >= LVL_F);
        host_dis = 1'b0;
        sw_dis = 1'b0;
        for (int i = 0; i < LANES; i++) begin
            // per-lane termination disable in serial mode
            host_dis = ctrl_reg[CTRL_TERM_DIS_LSB + i];
            sw_dis = ctrl_reg[CTRL_TERM_DIS_LSB + LANES + i];
            next_from_a[i] = sel_hi;
            next_term_host[i] = 1'b0;
            next_term_a[i] = 1'b0;
            next_term_b[i] = 1'b0;
            next_a_en[i] = 1'b0;
            next_b_en[i] = 1'b0;
            if (rst_pin_s || reserved) begin
                next_from_a[i] = 1'b0;
            end else begin
                if (lv_in_en != LVL_F) begin
                    next_term_host[i] = !host_dis;
                    next_term_a[i] = !sw_dis;
                    next_term_b[i] = !sw_dis;
                end else begin
                    next_term_host[i] = detected[i] && !host_dis;
                    next_term_a[i] = poll_a && detected[i] && !sw_dis;
                    next_term_b[i] = !poll_a && detected[i] && !sw_dis;
                end
                if (lv_in_en == LVL_ONE) begin
                    next_a_en[i] = 1'b1;
                    next_b_en[i] = 1'b1;
                end else begin
                    // select R or 1 goes to A, 0 or F to B
                    next_a_en[i] = lv_sel_a inside {LVL_R, LVL_ONE};
                    next_b_en[i] = lv_sel_a inside {LVL_ZERO, LVL_F};
                end
            end
        end
    end

    // registered outputs; reset leaves paths open and muted
    always_ff @(posedge clock) begin
        if (rst) begin
            op_mode <= MODE_PIN;
            slave_address <= ADDR_BASE;
            low_power <= 1'b1;
            idle_threshold <= LVL_ZERO;
            eq_code <= '0;
            output_swing <= '0;
            emph_level <= '0;
            term_host <= '0;
            term_switch_a <= '0;
            term_switch_b <= '0;
            host_tx_from_a <= '0;
            switch_a_tx_en <= '0;
            switch_b_tx_en <= '0;
        end else begin
            op_mode <= mode_now;
            slave_address <= next_address;
            // low power follows the reset pin
            low_power <= rst_pin_s;
            idle_threshold <= next_idle;
            eq_code <= next_eq;
            output_swing <= next_swing;
            emph_level <= next_emph;
            term_host <= next_term_host;
            term_switch_a <= next_term_a;
            term_switch_b <= next_term_b;
            host_tx_from_a <= next_from_a;
            switch_a_tx_en <= next_a_en;
            switch_b_tx_en <= next_b_en;
        end
    end

    // read data for the cycle after a read strobe, zero otherwise
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == REG_STATUS) begin
            next_rdata = {detected, poll_state, reserved, rst_pin_s, mode_now};
        end else if (reg_addr == REG_ADDRESS) begin
            next_rdata = next_address;
        end else if (reg_addr == REG_CTRL) begin
            next_rdata = ctrl_reg;
        end
        for (int g = 0; g < SET_LANES; g++) begin
            if (reg_addr == REG_EQ_BASE + 8'(g)) begin
                next_rdata = eq_reg[g];
            end
            if (reg_addr == REG_DRIVE_BASE + 8'(g)) begin
                next_rdata = drive_reg[g];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : rdm_control
`default_nettype wire

// ### src/rdm_pkg.sv
// shared constants, tables and types for the redriver mux control block
// assumes one 125 MHz clock and strap levels given as comparator outputs
package rdm_pkg;

    // lane counts: two data lanes, four conditioning settings
    localparam int LANES = 2;
    localparam int SET_LANES = 4;

    // clock and time figures
    localparam longint CLK_HZ = 125_000_000;
    localparam longint POLL_PERIOD_MS = 12;
    localparam longint SETTLE_NS = 1000;
    localparam int POLL_CYCLES_DEFAULT = int'(POLL_PERIOD_MS * CLK_HZ / 1000);
    localparam int SETTLE_CYCLES_DEFAULT =
        int'((SETTLE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

    // positions of each input in the synchroniser bank
    localparam int IDX_SERIAL = 0;
    localparam int IDX_IDLE = 1;
    localparam int IDX_HEQ_HI = 2;
    localparam int IDX_HEQ_LO = 3;
    localparam int IDX_SEQ_HI = 4;
    localparam int IDX_SEQ_LO = 5;
    localparam int IDX_HEM_HI = 6;
    localparam int IDX_HEM_LO = 7;
    localparam int IDX_SEM_HI = 8;
    localparam int IDX_SEM_LO = 9;
    localparam int IDX_SEL_A = 10;
    localparam int IDX_SEL_B = 11;
    localparam int IDX_IN_EN = 12;
    localparam int IDX_RESET = 13;
    localparam int IDX_DET = 14;
    localparam int STRAP_COUNT = 16;

    // resolved four-level pin state
    typedef enum logic [1:0] {
        LVL_ZERO = 2'h0,
        LVL_R = 2'h1,
        LVL_F = 2'h2,
        LVL_ONE = 2'h3
    } rdm_level_type;

    // operating mode from the serial-mode strap
    typedef enum logic [1:0] {
        MODE_PIN = 2'h0,
        MODE_SLAVE = 2'h1,
        MODE_MASTER = 2'h3
    } rdm_mode_type;

    // receiver-detect poll sequence, gray along off-test-wait-done
    typedef enum logic [1:0] {
        POLL_OFF = 2'h0,
        POLL_TEST = 2'h1,
        POLL_WAIT = 2'h3,
        POLL_DONE = 2'h2
    } rdm_poll_type;

    // register offsets and field positions
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_ADDRESS = 8'h01;
    localparam logic [7:0] REG_CTRL = 8'h02;
    localparam logic [7:0] REG_EQ_BASE = 8'h04;
    localparam logic [7:0] REG_DRIVE_BASE = 8'h08;
    localparam int CTRL_IDLE_OVR = 0;
    localparam int CTRL_IDLE_LSB = 1;
    localparam int CTRL_TERM_DIS_LSB = 4;
    localparam int DRIVE_SWING_LSB = 4;
    localparam int DRIVE_EMPH_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] EQ_RESET = 8'h00;
    localparam logic [7:0] DRIVE_RESET = 8'h30;

    // slave address byte base, step of two per address input count
    localparam logic [7:0] ADDR_BASE = 8'hB0;

    // swing codes: 0.6 0.8 0.9 1.0 1.1 1.2 V; emphasis: 0 -3.5 -6 -9 dB
    // tables are indexed by {hi level, lo level}
    localparam logic [7:0] EQ_TABLE [16] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0B, 8'h0F,
        8'h55, 8'h1F, 8'h2F, 8'h3F, 8'hAA, 8'h7F, 8'hBF, 8'hFF};
    localparam logic [2:0] SWING_TABLE [16] = '{
        3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
        3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5};
    localparam logic [1:0] EMPH_TABLE [16] = '{
        2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1,
        2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};

endpackage : rdm_pkg

// ### src/rdm_strap_if.sv
// carrier for resolved pin levels between synchroniser and control
// assumes one producer and one consumer on the same clock
`timescale 1ns/10ps
`default_nettype none
interface rdm_strap_if
    import rdm_pkg::*;
#(
    parameter int N = STRAP_COUNT
);
    rdm_level_type level [N];

    modport sync (output level);
    modport user (input level);
endinterface : rdm_strap_if
`default_nettype wire

// ### src/rdm_strap_sync.sv
// three-flop synchroniser bank with four-level decode per input
// assumes raw inputs are asynchronous comparator outputs
`timescale 1ns/10ps
`default_nettype none
module rdm_strap_sync
    import rdm_pkg::*;
#(
    parameter int N = STRAP_COUNT
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // thermometer bits {above 0.8, above 0.5, above 0.2} per input
    input wire logic [N-1:0][2:0] raw,
    // resolved levels
    rdm_strap_if.sync strap
);
    logic [N-1:0][2:0] meta;
    logic [N-1:0][2:0] sync2;
    logic [N-1:0][2:0] sync3;

    // a comparator bubble still resolves to the count of set bits
    function automatic rdm_level_type decode(input logic [2:0] t);
        logic [1:0] sum;
        sum = {1'b0, t[0]} + {1'b0, t[1]} + {1'b0, t[2]};
        return rdm_level_type'(sum);
    endfunction : decode

    // synchroniser chain; meta feeds only sync2
    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            meta <= raw;
            sync2 <= meta;
            sync3 <= sync2;
        end
    end

    // a level is taken once the last two stages agree
    for (genvar i = 0; i < N; i++) begin : g_level
        always_ff @(posedge clock) begin
            if (rst) begin
                strap.level[i] <= LVL_ZERO;
            end else if (sync2[i] == sync3[i]) begin
                strap.level[i] <= decode(sync3[i]);
            end
        end
    end

endmodule : rdm_strap_sync
`default_nettype wire

// ### testbench/rdm_control_sva.sv
// concurrent checks on the redriver control ports
// assumes one clock with rst synchronous active high
`timescale 1ns/10ps
`default_nettype none
module rdm_control_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic reset_pin,
    input wire logic [2:0] input_enable_strap,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] op_mode,
    input wire logic [7:0] slave_address,
    input wire logic low_power,
    input wire logic [1:0] term_host,
    input wire logic rx_detect_start,
    input wire logic [1:0] switch_a_tx_en,
    input wire logic [1:0] switch_b_tx_en
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    a_rdata_one_cycle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    a_pin_low_power: assert property (
        reset_pin [*6] |-> low_power) else $error("reset pin not sleeping");
    a_sleep_inputs_open: assert property (
        low_power [*3] |-> term_host == 2'h0) else $error("input terminated");
    a_sleep_outputs_mute: assert property (
        low_power [*3] |-> (switch_a_tx_en | switch_b_tx_en) == 2'h0)
        else $error("output driven in sleep");
    a_detect_pulse_once: assert property (
        rx_detect_start |=> !rx_detect_start [*8]) else $error("detect burst");
    a_mode_code: assert property (
        op_mode != 2'h2) else $error("bad mode code");
    a_address_step: assert property (
        !slave_address[0] && slave_address inside {[8'hB0:8'hCE]})
        else $error("address byte out of range");
    a_mux_one_side: assert property (
        (input_enable_strap == 3'h0) [*6] |->
        (switch_a_tx_en & switch_b_tx_en) == 2'h0) else $error("mux on both");
endmodule : rdm_control_sva
bind rdm_control rdm_control_sva rdm_control_sva_i (.clock, .rst, .reset_pin,
    .input_enable_strap, .reg_rd, .reg_rdata, .op_mode, .slave_address,
    .low_power, .term_host, .rx_detect_start, .switch_a_tx_en, .switch_b_tx_en);
`default_nettype wire

// ### testbench/rdm_rx_model.sv
// receiver presence model on the switch-side outputs
// assumes detect requests arrive as one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module rdm_rx_model (
    input wire logic clock,
    input wire logic rx_detect_start,
    input wire logic [1:0] present,
    output logic [1:0] hit = 2'h0
);
    always @(posedge clock) if (rx_detect_start) hit <= present;
endmodule : rdm_rx_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the redriver control block
// assumes shortened poll counts and the receiver model beside it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic [2:0] s [13];
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, reset_pin = 0;
    logic low_power, rx_detect_start;
    logic [1:0] present = 2'h3, rx_detect_hit, op_mode, idle_threshold;
    logic [1:0] term_host, term_switch_a, term_switch_b, host_tx_from_a;
    logic [1:0] switch_a_tx_en, switch_b_tx_en;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [7:0] reg_rdata, slave_address, v;
    logic [3:0][7:0] eq_code;
    logic [3:0][2:0] output_swing;
    logic [3:0][1:0] emph_level;
    int n_fail = 0, total_checks = 0, n;
    // expected eq code and {swing, emphasis} per {hi, lo} level, lsb first
    localparam logic [127:0] EQX = 128'hFFBF7FAA3F2F1F550F0B150703020100;
    localparam logic [127:0] DRX = 128'h171615141211100E0D0C0A0908050400;
    always #4 clock = ~clock;
    rdm_control #(.POLL_CYCLES(50), .SETTLE_CYCLES(4)) rdm_control_i (
        .clock, .rst, .serial_mode_strap(s[0]), .idle_threshold_strap(s[1]),
        .host_eq_pin_hi(s[2]), .host_eq_pin_lo(s[3]), .switch_eq_pin_hi(s[4]),
        .switch_eq_pin_lo(s[5]), .host_emph_pin_hi(s[6]),
        .host_emph_pin_lo(s[7]), .switch_emph_pin_hi(s[8]),
        .switch_emph_pin_lo(s[9]), .path_select_a(s[10]),
        .path_select_b(s[11]), .input_enable_strap(s[12]), .reset_pin,
        .rx_detect_hit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .op_mode, .slave_address, .low_power, .idle_threshold, .eq_code,
        .output_swing, .emph_level, .term_host, .term_switch_a, .term_switch_b,
        .rx_detect_start, .host_tx_from_a, .switch_a_tx_en, .switch_b_tx_en);
    rdm_rx_model rdm_rx_model_i (.clock, .rx_detect_start, .present,
        .hit(rx_detect_hit));
    task automatic chk(input string w, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) n_fail++;
        if (g !== e) $display("mismatch %s exp %h got %h", w, e, g);
    endtask : chk
    // strap as thermometer bits, then wait out synchroniser and output flop
    task automatic pin(input int k, l);
        @(posedge clock);
        s[k] <= {l > 2, l > 1, l > 0};
        repeat (8) @(posedge clock);
        #1;
    endtask : pin
    // one register cycle; read data taken in the single cycle it stands
    task automatic acc(input logic w, input logic [7:0] a, x);
        @(posedge clock);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, x};
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'h0;
        #1 v = reg_rdata;
    endtask : acc
    task automatic complete_run;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // main sequence: pin tables, registers, reset pin, paths, detect poll
    initial begin
        foreach (s[i]) s[i] = 3'h0;
        void'($urandom(85));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            // switch-side pins take the mirrored index so the sides differ
            for (int k = 1; k < 10; k++) pin(k, (k % 2 ? i % 4 : i / 4)
                ^ (k inside {4, 5, 8, 9} ? 3 : 0));
            chk("eq", {EQX[i*8+:8], EQX[(15-i)*8+:8]},
                {eq_code[0], eq_code[3]});
            chk("drive", {DRX[i*8+:8], 8'(i % 4)}, {3'h0, output_swing[1],
                emph_level[1], 6'h0, idle_threshold});
        end
        pin(0, 3);
        chk("slave", 16'h01B6, {6'h0, op_mode, slave_address});
        n = $urandom;
        acc(1'b1, 8'h07, n[7:0]);
        acc(1'b0, 8'h07, 8'h00);
        chk("lane", {2{n[7:0]}}, {v, eq_code[3]});
        @(posedge clock);
        reset_pin <= 1'b1;
        pin(12, 1);
        chk("sleep", 16'h0004, {13'h0, low_power, term_host});
        @(posedge clock);
        reset_pin <= 1'b0;
        acc(1'b0, 8'h07, 8'h00);
        chk("keep", {8'h00, n[7:0]}, {8'h00, v});
        pin(0, 0);
        pin(0, 2);
        acc(1'b0, 8'h07, 8'h00);
        chk("clear", 16'h0300, {6'h0, op_mode, v});
        pin(12, 3);
        chk("fanout", 16'h00F3, {8'h00, switch_a_tx_en, switch_b_tx_en,
            host_tx_from_a, term_switch_a});
        pin(10, 2);
        chk("reserved", 16'h0000, {4'h0, term_host, term_switch_a,
            term_switch_b, switch_a_tx_en, switch_b_tx_en, host_tx_from_a});
        pin(11, 2);
        pin(12, 2);
        for (n = 0; n < 300 && term_switch_a !== 2'h3; n++) #8;
        if (n == 300) chk("poll wait", 16'h0000, 16'h0001);
        chk("poll", 16'h0F0F, {4'h0, term_host, term_switch_a, term_switch_b,
            switch_a_tx_en, switch_b_tx_en, host_tx_from_a});
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
